// ### common/dme_consts.svh
`ifndef DME_CONSTS_SVH
`define DME_CONSTS_SVH

// register byte offsets
`define DME_CTRL_OFS    8'h00
`define DME_TRAPEN_OFS  8'h04
`define DME_STATUS_OFS  8'h08
`define DME_ACC_ALO_OFS 8'h0C
`define DME_ACC_AHI_OFS 8'h10
`define DME_ACC_BLO_OFS 8'h14
`define DME_ACC_BHI_OFS 8'h18
`define DME_MULRES_OFS  8'h1C

// core control word fields and reset value
`define DME_CTRL_RST    16'h0020
`define DME_CTRL_MASK   16'h10F3
`define DME_BIT_UNS_MUL   12
`define DME_BIT_SATEN_A   7
`define DME_BIT_SATEN_B   6
`define DME_BIT_SAT_DWR   5
`define DME_BIT_SAT_WIDTH 4
`define DME_BIT_ROUND     1
`define DME_BIT_IF      0

// trap enable fields
`define DME_TRAPEN_MASK 16'h0700
`define DME_BIT_TRAP_GRD_A 10
`define DME_BIT_TRAP_GRD_B 9
`define DME_BIT_TRAP_CAT   8

// status word fields
`define DME_BIT_GRD_A    15
`define DME_BIT_GRD_B    14
`define DME_BIT_SATD_A   13
`define DME_BIT_SATD_B   12
`define DME_BIT_GRD_ANY  11
`define DME_BIT_SATD_ANY 10

// saturation values
`define DME_SAT40_POS   40'h7FFFFFFFFF
`define DME_SAT40_NEG   40'h8000000000
`define DME_SAT32_POS   40'h007FFFFFFF
`define DME_SAT32_NEG   40'h0080000000

`endif

// ### common/dme_pkg.sv
`default_nettype none
package dme_pkg;

   typedef enum logic [3:0]
   {
      DME_OP_CLR,
      DME_OP_MPY,
      DME_OP_MPY_NEG,
      DME_OP_MAC,
      DME_OP_MSC,
      DME_OP_ADD_ACC,
      DME_OP_SUB_ACC,
      DME_OP_NEG_ACC,
      DME_OP_LOAD_ACC,
      DME_OP_ADD_DATA,
      DME_OP_INT_MUL
   } dme_op_t;

   typedef struct packed
   {
      logic              valid;
      dme_op_t           op;
      logic              acc_sel;
      logic [15:0]       x;
      logic [15:0]       y;
      logic [15:0]       data;
      logic signed [5:0] shift;
      logic              mul_byte;
      logic              x_uns;
      logic              y_uns;
   } dme_op_req_t;

   typedef struct packed
   {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } dme_apb_req_t;

endpackage
`default_nettype wire

// ### logic/dme_engine.sv
`timescale 1ns/10ps
`default_nettype none
`include "dme_consts.svh"

module dme_engine
   import dme_pkg::*;
(
   input  wire logic         i_clk,
   input  wire logic         i_sys_rst,
   input  wire dme_apb_req_t i_apb,
   output logic              o_pready,
   output logic [31:0]       o_prdata,
   output logic              o_pslverr,
   input  wire dme_op_req_t  i_op,
   output logic [31:0]       o_mul_result,
   output logic              o_mul_valid,
   output logic              o_trap_req,
   output logic [15:0]       o_status
);

   logic [15:0] ctrl_q;
   logic [15:0] trapen_q;
   logic [39:0] acc_a_q;
   logic [39:0] acc_b_q;
   logic        guard_a_q;
   logic        guard_b_q;
   logic        sat_a_q;
   logic        sat_b_q;
   logic [31:0] mul_res_q;
   logic        mul_valid_q;
   logic        trap_q;
   logic        pready_q;
   logic [31:0] prdata_q;
   logic        pslverr_q;

   // operand into 17-bit multiplier input
   function automatic logic signed [16:0] ext17(input logic [15:0] v, input logic uns);
      ext17 = {(uns ? 1'b0 : v[15]), v};
   endfunction

   // positive amount shifts right (arithmetic), negative shifts left
   function automatic logic [39:0] bshift(input logic [39:0] v, input logic signed [5:0] s);
      logic [5:0] mag;
      mag = s[5] ? 6'(-s) : 6'(s);
      if (s[5])
         bshift = v << mag;
      else
         bshift = 40'($signed(v) >>> mag);
   endfunction

   function automatic logic [15:0] byte_ext(input logic [15:0] v, input logic uns);
      byte_ext = {{8{~uns & v[7]}}, v[7:0]};
   endfunction

   // datapath
   logic [39:0]        tgt;
   logic [39:0]        oth;
   logic [15:0]        mx;
   logic [15:0]        my;
   logic               mxu;
   logic               myu;
   logic signed [33:0] prod;
   logic [32:0]        prod33;
   logic [39:0]        prod40;
   logic [39:0]        data40;
   logic [39:0]        a_in;
   logic [39:0]        b_in;
   logic [39:0]        b_eff;
   logic               sub;
   logic               acc_op;
   logic [40:0]        sum;
   logic [39:0]        res;
   logic               ovf39;
   logic               ovf31;
   logic               sat_en;
   logic               sat40;
   logic [39:0]        acc_new;
   logic               guard_new;
   logic               sat_new;
   logic               trap_new;
   logic [31:0]        imul;

   always_comb
   begin
      tgt = i_op.acc_sel ? acc_b_q : acc_a_q;
      oth = i_op.acc_sel ? acc_a_q : acc_b_q;
      // one multiplier shared by engine and integer multiply
      if (i_op.op == DME_OP_INT_MUL)
      begin
         mxu = i_op.x_uns;
         myu = i_op.y_uns;
         mx  = i_op.mul_byte ? byte_ext(i_op.x, i_op.x_uns) : i_op.x;
         my  = i_op.mul_byte ? byte_ext(i_op.y, i_op.y_uns) : i_op.y;
      end
      else
      begin
         mxu = ctrl_q[`DME_BIT_UNS_MUL];
         myu = ctrl_q[`DME_BIT_UNS_MUL];
         mx  = i_op.x;
         my  = i_op.y;
      end
      prod = ext17(mx, mxu) * ext17(my, myu);
      if (ctrl_q[`DME_BIT_IF])
         prod33 = prod[32:0];
      else
         prod33 = {prod[31:0], 1'b0};
      prod40 = {{7{prod33[32]}}, prod33};
      imul   = i_op.mul_byte ? {16'h0000, prod[15:0]} : prod[31:0];
      // data word enters as 1.15 in bits 16..31
      data40 = bshift({{8{i_op.data[15]}}, i_op.data, 16'h0000}, i_op.shift);
      a_in   = 40'h0000000000;
      b_in   = 40'h0000000000;
      sub    = 1'b0;
      acc_op = 1'b1;
      unique case (i_op.op)
         DME_OP_CLR:
            b_in = 40'h0000000000;
         DME_OP_MPY:
            b_in = prod40;
         DME_OP_MPY_NEG:
         begin
            b_in = prod40;
            sub  = 1'b1;
         end
         DME_OP_MAC:
         begin
            a_in = tgt;
            b_in = prod40;
         end
         DME_OP_MSC:
         begin
            a_in = tgt;
            b_in = prod40;
            sub  = 1'b1;
         end
         DME_OP_ADD_ACC:
         begin
            a_in = tgt;
            b_in = oth;
         end
         DME_OP_SUB_ACC:
         begin
            a_in = tgt;
            b_in = oth;
            sub  = 1'b1;
         end
         DME_OP_NEG_ACC:
         begin
            b_in = tgt;
            sub  = 1'b1;
         end
         DME_OP_LOAD_ACC:
            b_in = data40;
         DME_OP_ADD_DATA:
         begin
            a_in = tgt;
            b_in = data40;
         end
         DME_OP_INT_MUL:
            acc_op = 1'b0;
      endcase
      // zero on a side, complement with active-low borrow on subtract
      b_eff = sub ? ~b_in : b_in;
      sum   = {1'b0, a_in} + {1'b0, b_eff} + {40'h0000000000, sub};
      res   = sum[39:0];
      ovf39 = (a_in[39] == b_eff[39]) && (res[39] != a_in[39]);
      ovf31 = ~((&res[39:31]) | ~(|res[39:31]));
      sat_en    = i_op.acc_sel ? ctrl_q[`DME_BIT_SATEN_B] : ctrl_q[`DME_BIT_SATEN_A];
      sat40     = ctrl_q[`DME_BIT_SAT_WIDTH];
      acc_new   = res;
      sat_new   = 1'b0;
      if (sat_en && sat40)
      begin
         if (ovf39)
         begin
            acc_new = res[39] ? `DME_SAT40_POS : `DME_SAT40_NEG;
            sat_new = 1'b1;
         end
      end
      else if (sat_en)
      begin
         if (ovf39 || ovf31)
         begin
            // true sign is the flipped result bit after a bit 39 wrap
            if (ovf39 ? res[39] : ~res[39])
               acc_new = `DME_SAT32_POS;
            else
               acc_new = `DME_SAT32_NEG;
            sat_new = 1'b1;
         end
      end
      else
         sat_new = ovf39;
      // guard bits idle under 1.31 saturation
      guard_new = ~(sat_en && !sat40) && ~((&acc_new[39:32]) | ~(|acc_new[39:32]));
      trap_new = (guard_new && (i_op.acc_sel ? trapen_q[`DME_BIT_TRAP_GRD_B]
                                             : trapen_q[`DME_BIT_TRAP_GRD_A]))
               || (!sat_en && sat_new && trapen_q[`DME_BIT_TRAP_CAT]);
   end

   // issue strobe is a single cycle per operation
   logic do_op;
   logic do_acc;
   assign do_op  = i_op.valid;
   assign do_acc = do_op && acc_op;
   // APB decode
   logic acc_cyc;
   logic wr_cyc;
   assign acc_cyc = i_apb.psel && i_apb.penable && pready_q;
   assign wr_cyc  = acc_cyc && i_apb.pwrite;
   logic status_wr;
   assign status_wr = wr_cyc && (i_apb.paddr == `DME_STATUS_OFS);

   // accumulators, written in the issuing cycle
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         acc_a_q <= 40'h0000000000;
         acc_b_q <= 40'h0000000000;
      end
      else if (do_acc)
      begin
         if (i_op.acc_sel)
            acc_b_q <= acc_new;
         else
            acc_a_q <= acc_new;
      end
   end

   // guard flags follow the last pass only
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         guard_a_q <= 1'b0;
         guard_b_q <= 1'b0;
      end
      else if (do_acc)
      begin
         if (i_op.acc_sel)
            guard_b_q <= guard_new;
         else
            guard_a_q <= guard_new;
      end
   end

   // sticky saturation; a set in the clearing cycle wins
   logic clr_a;
   logic clr_b;
   assign clr_a = status_wr && (i_apb.pwdata[`DME_BIT_SATD_A] || i_apb.pwdata[`DME_BIT_SATD_ANY]);
   assign clr_b = status_wr && (i_apb.pwdata[`DME_BIT_SATD_B] || i_apb.pwdata[`DME_BIT_SATD_ANY]);
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         sat_a_q <= 1'b0;
         sat_b_q <= 1'b0;
      end
      else
      begin
         sat_a_q <= (do_acc && !i_op.acc_sel && sat_new) || (sat_a_q && !clr_a);
         sat_b_q <= (do_acc && i_op.acc_sel && sat_new) || (sat_b_q && !clr_b);
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         trap_q <= 1'b0;
      else
         trap_q <= do_acc && trap_new;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         mul_res_q   <= 32'h00000000;
         mul_valid_q <= 1'b0;
      end
      else
      begin
         mul_valid_q <= do_op && !acc_op;
         if (do_op && !acc_op)
            mul_res_q <= imul;
      end
   end

   // control and trap enable registers
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         ctrl_q   <= `DME_CTRL_RST;
         trapen_q <= 16'h0000;
      end
      else if (wr_cyc)
      begin
         if (i_apb.paddr == `DME_CTRL_OFS)
            ctrl_q <= i_apb.pwdata[15:0] & `DME_CTRL_MASK;
         if (i_apb.paddr == `DME_TRAPEN_OFS)
            trapen_q <= i_apb.pwdata[15:0] & `DME_TRAPEN_MASK;
      end
   end
   logic [15:0] status_w;
   always_comb
   begin
      status_w                     = 16'h0000;
      status_w[`DME_BIT_GRD_A]     = guard_a_q;
      status_w[`DME_BIT_GRD_B]     = guard_b_q;
      status_w[`DME_BIT_SATD_A]    = sat_a_q;
      status_w[`DME_BIT_SATD_B]    = sat_b_q;
      status_w[`DME_BIT_GRD_ANY]   = guard_a_q | guard_b_q;
      status_w[`DME_BIT_SATD_ANY]  = sat_a_q | sat_b_q;
   end

   // no wait state: ready rises in the first access cycle
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h00000000;
         pslverr_q <= 1'b0;
      end
      else
      begin
         pready_q  <= i_apb.psel && !i_apb.penable;
         pslverr_q <= 1'b0;
         if (i_apb.psel && !i_apb.penable)
         begin
            unique case (i_apb.paddr)
               `DME_CTRL_OFS:    prdata_q <= {16'h0000, ctrl_q};
               `DME_TRAPEN_OFS:  prdata_q <= {16'h0000, trapen_q};
               `DME_STATUS_OFS:  prdata_q <= {16'h0000, status_w};
               `DME_ACC_ALO_OFS: prdata_q <= acc_a_q[31:0];
               `DME_ACC_AHI_OFS: prdata_q <= {24'h000000, acc_a_q[39:32]};
               `DME_ACC_BLO_OFS: prdata_q <= acc_b_q[31:0];
               `DME_ACC_BHI_OFS: prdata_q <= {24'h000000, acc_b_q[39:32]};
               `DME_MULRES_OFS:  prdata_q <= mul_res_q;
               default:
               begin
                  prdata_q  <= 32'h00000000;
                  pslverr_q <= 1'b1;
               end
            endcase
         end
      end
   end
   logic [15:0] status_q;
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         status_q <= 16'h0000;
      else
         status_q <= status_w;
   end
   assign o_pready     = pready_q;
   assign o_prdata     = prdata_q;
   assign o_pslverr    = pslverr_q;
   assign o_mul_result = mul_res_q;
   assign o_mul_valid  = mul_valid_q;
   assign o_trap_req   = trap_q;
   assign o_status     = status_q;

endmodule
`default_nettype wire

// ### tb/dme_engine_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "dme_consts.svh"
module dme_engine_checker
   import dme_pkg::*;
(
   input wire logic         i_clk,
   input wire logic         i_sys_rst,
   input wire dme_apb_req_t i_apb,
   input wire logic         o_pready,
   input wire logic [31:0]  o_prdata,
   input wire logic         o_pslverr,
   input wire dme_op_req_t  i_op,
   input wire logic [31:0]  o_mul_result,
   input wire logic         o_mul_valid,
   input wire logic         o_trap_req,
   input wire logic [15:0]  o_status
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);
   logic imul;
   logic clr_sat_a;
   assign imul = i_op.valid && (i_op.op == DME_OP_INT_MUL);
   assign clr_sat_a = i_apb.psel && i_apb.penable && o_pready && i_apb.pwrite
                   && (i_apb.paddr == `DME_STATUS_OFS) && (i_apb.pwdata[13] || i_apb.pwdata[10]);
   sequence s_setup;
      i_apb.psel && !i_apb.penable;
   endsequence
   sequence s_answer;
      (i_apb.penable && o_pready) ##1 !o_pready;
   endsequence
   AST_APB_WAIT: assert property (s_setup |=> s_answer)
      else $error("apb answer not in first access cycle");
   AST_ERR_ZERO: assert property (o_pslverr |-> o_pready && o_prdata == 32'h00000000)
      else $error("error response without ready or with data");
   AST_MUL_PULSE: assert property (imul |=> o_mul_valid)
      else $error("multiply result not flagged");
   AST_MUL_CAUSE: assert property (o_mul_valid |-> $past(imul))
      else $error("multiply flag without multiply");
   AST_MUL_HOLD: assert property (!o_mul_valid |-> $stable(o_mul_result))
      else $error("multiply result moved");
   AST_BYTE_UP: assert property (imul && i_op.mul_byte |=> o_mul_result[31:16] == 16'h0000)
      else $error("byte multiply upper half not zero");
   AST_GRD_ANY: assert property (o_status[11] == (o_status[15] | o_status[14]))
      else $error("combined guard flag wrong");
   AST_SATD_ANY: assert property (o_status[10] == (o_status[13] | o_status[12]))
      else $error("combined saturated flag wrong");
   AST_TRAP_CAUSE: assert property (o_trap_req |-> $past(i_op.valid))
      else $error("trap without operation");
   AST_STICKY: assert property ($fell(o_status[13]) |-> $past(clr_sat_a) || $past(clr_sat_a, 2))
      else $error("saturated flag dropped without software clear");
endmodule
bind dme_engine dme_engine_checker chk_u (.i_clk, .i_sys_rst, .i_apb, .o_pready, .o_prdata,
   .o_pslverr, .i_op, .o_mul_result, .o_mul_valid, .o_trap_req, .o_status);
`default_nettype wire

// ### tb/dme_seq_model.sv
`timescale 1ns/10ps
`default_nettype none
module dme_seq_model
   import dme_pkg::*;
(
   input  wire logic  i_clk,
   output dme_op_req_t o_op
);
   initial o_op = '0;
   // released operands flip so a stale value is never mistaken for a live one
   task automatic issue(input dme_op_t op, input logic acc, input logic [15:0] x,
                        input logic [15:0] y, input logic [2:0] mf, input int n);
      repeat (n)
      begin
         @(posedge i_clk);
         o_op <= '{1'b1, op, acc, x, y, 16'h0000, 6'sd0, mf[2], mf[1], mf[0]};
      end
      @(posedge i_clk);
      o_op <= '{1'b0, op, acc, ~x, ~y, 16'hFFFF, 6'sd0, 1'b0, 1'b0, 1'b0};
   endtask
   // data-path ops carry a 1.15 word and a shift amount instead of operands
   task automatic issue_data(input dme_op_t op, input logic acc, input logic [15:0] d,
                             input logic signed [5:0] sh);
      @(posedge i_clk);
      o_op <= '{1'b1, op, acc, 16'h0000, 16'h0000, d, sh, 1'b0, 1'b0, 1'b0};
      @(posedge i_clk);
      o_op <= '{1'b0, op, acc, 16'hFFFF, 16'hFFFF, ~d, 6'sd0, 1'b0, 1'b0, 1'b0};
   endtask
endmodule
`default_nettype wire

// ### tb/dme_engine_test.sv
`timescale 1ns/10ps
`default_nettype none
module dme_engine_test;
   import dme_pkg::*;
   logic         i_clk;
   logic         i_sys_rst;
   dme_apb_req_t apb;
   dme_op_req_t  op_w;
   logic         pready;
   logic [31:0]  prdata;
   logic         pslverr;
   logic [31:0]  mul_res;
   logic         mul_v;
   logic         trap;
   logic [15:0]  status;
   int           err_total;
   int           compares;
   int           n_trap;
   int           n_mul;
   logic [31:0]  rv;
   logic         re;
   dme_engine dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_apb(apb), .o_pready(pready),
      .o_prdata(prdata), .o_pslverr(pslverr), .i_op(op_w), .o_mul_result(mul_res),
      .o_mul_valid(mul_v), .o_trap_req(trap), .o_status(status));
   dme_seq_model seq_u (.i_clk(i_clk), .o_op(op_w));
   initial
   begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   always @(posedge i_clk)
   begin
      if (trap === 1'b1) n_trap++;
      if (mul_v === 1'b1) n_mul++;
   end
   task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_total++;
         $display("ERROR %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk);
      apb <= '{1'b1, 1'b0, wr, a, d};
      @(posedge i_clk);
      apb.penable <= 1'b1;
      do
      begin
         @(posedge i_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) err_total++;
      rv = prdata;
      re = pslverr;
      apb <= '0;
   endtask
   task automatic chk_reg(input string nm, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h00000000);
      chk(nm, {8'h00, rv & (a == 8'h08 ? 32'h0000FC00 : 32'hFFFFFFFF)}, {8'h00, exp});
   endtask
   task automatic chk_acc(input string nm, input logic s, input logic [39:0] exp);
      logic [31:0] lo;
      bus(1'b0, s ? 8'h14 : 8'h0C, 32'h00000000);
      lo = rv;
      bus(1'b0, s ? 8'h18 : 8'h10, 32'h00000000);
      chk(nm, {rv[7:0], lo}, exp);
   endtask
   task automatic op(input dme_op_t o, input logic s, input logic [15:0] x, y, input int n);
      seq_u.issue(o, s, x, y, 3'b000, n);
   endtask
   task automatic t_regs;
      chk_reg("ctl rst", 8'h00, 32'h00000020);
      chk_reg("sts rst", 8'h08, 32'h00000000);
      bus(1'b0, 8'h20, 32'h00000000);
      chk("unmapped", {7'h00, re, rv}, {8'h01, 32'h00000000});
      bus(1'b1, 8'h00, 32'hFFFFFFFF);
      chk_reg("ctl mask", 8'h00, 32'h000010F3);
      $display("t_regs done");
   endtask
   task automatic t_frac;
      bus(1'b1, 8'h00, 32'h00000000);
      op(DME_OP_MPY, 1'b0, 16'h4000, 16'h4000, 1);
      chk_acc("frac a", 1'b0, 40'h0020000000);
      op(DME_OP_MPY, 1'b1, 16'h8000, 16'h4000, 1);
      chk_acc("frac b", 1'b1, 40'hFFC0000000);
      op(DME_OP_ADD_ACC, 1'b0, 16'h0000, 16'h0000, 1);
      chk_acc("add acc", 1'b0, 40'hFFE0000000);
      op(DME_OP_SUB_ACC, 1'b1, 16'h0000, 16'h0000, 1);
      chk_acc("sub acc", 1'b1, 40'hFFE0000000);
      bus(1'b1, 8'h00, 32'h00000001);
      op(DME_OP_MPY, 1'b0, 16'hFFFF, 16'h0002, 1);
      chk_acc("int sgn", 1'b0, 40'hFFFFFFFFFE);
      bus(1'b1, 8'h00, 32'h00001001);
      op(DME_OP_MPY, 1'b0, 16'hFFFF, 16'h0002, 1);
      chk_acc("int uns", 1'b0, 40'h000001FFFE);
      $display("t_frac done");
   endtask
   task automatic t_imul;
      logic [2:0]  mf [4] = '{3'b011, 3'b000, 3'b111, 3'b100};
      logic [31:0] ex [4] = '{32'hFFFE0001, 32'h00000001, 32'h000001FE, 32'h0000FFFE};
      logic [15:0] xv;
      for (int i = 0; i < 4; i++)
      begin
         xv = (i < 2) ? 16'hFFFF : 16'h12FF;
         seq_u.issue(DME_OP_INT_MUL, 1'b0, xv, (i < 2) ? 16'hFFFF : 16'h3402, mf[i], 1);
         @(posedge i_clk);
         chk("int mul", {8'h00, mul_res}, {8'h00, ex[i]});
      end
      @(posedge i_clk);
      chk("mul pulses", 40'(n_mul), 40'd4);
      $display("t_imul done");
   endtask
   task automatic t_guard;
      bus(1'b1, 8'h00, 32'h00000000);
      bus(1'b1, 8'h04, 32'h00000400);
      op(DME_OP_MPY, 1'b0, 16'h8000, 16'h8000, 1);
      chk_reg("no guard", 8'h08, 32'h00000000);
      op(DME_OP_MAC, 1'b0, 16'h8000, 16'h8000, 1);
      chk_acc("mac a", 1'b0, 40'h0100000000);
      chk_reg("guard a", 8'h08, 32'h00008800);
      chk("trap a", 40'(n_trap), 40'd1);
      op(DME_OP_MPY, 1'b1, 16'h8000, 16'h8000, 1);
      op(DME_OP_MAC, 1'b1, 16'h8000, 16'h8000, 1);
      op(DME_OP_CLR, 1'b0, 16'h0000, 16'h0000, 1);
      chk_reg("guard b", 8'h08, 32'h00004800);
      chk("no trap b", 40'(n_trap), 40'd1);
      $display("t_guard done");
   endtask
   task automatic t_sat;
      bus(1'b1, 8'h00, 32'h00000080);
      op(DME_OP_MPY, 1'b0, 16'h8000, 16'h8000, 1);
      chk_acc("sat32", 1'b0, 40'h007FFFFFFF);
      op(DME_OP_MPY, 1'b0, 16'h4000, 16'h4000, 1);
      chk_reg("sticky", 8'h08, 32'h00006C00);
      chk("no trap32", 40'(n_trap), 40'd1);
      bus(1'b1, 8'h08, 32'h00002000);
      chk_reg("sw clear", 8'h08, 32'h00004800);
      bus(1'b1, 8'h04, 32'h00000000);
      bus(1'b1, 8'h00, 32'h00000090);
      op(DME_OP_MPY, 1'b0, 16'h8000, 16'h8000, 1);
      op(DME_OP_MAC, 1'b0, 16'h8000, 16'h8000, 255);
      chk_acc("sat40", 1'b0, 40'h7FFFFFFFFF);
      chk_reg("sat40 sts", 8'h08, 32'h0000EC00);
      $display("t_sat done");
   endtask
   task automatic t_cat;
      bus(1'b1, 8'h00, 32'h00000000);
      bus(1'b1, 8'h04, 32'h00000100);
      bus(1'b1, 8'h08, 32'h00000400);
      chk_reg("sab clear", 8'h08, 32'h0000C800);
      op(DME_OP_MPY, 1'b1, 16'h8000, 16'h8000, 1);
      op(DME_OP_ADD_ACC, 1'b0, 16'h0000, 16'h0000, 1);
      chk_acc("wrap", 1'b0, 40'h807FFFFFFF);
      chk_reg("cat sts", 8'h08, 32'h0000AC00);
      chk("cat trap", 40'(n_trap), 40'd2);
      chk("sts port", {24'h000000, status & 16'hFC00}, 40'h000000AC00);
      $display("t_cat done");
   endtask
   task automatic t_data;
      bus(1'b1, 8'h04, 32'h00000000);
      seq_u.issue_data(DME_OP_LOAD_ACC, 1'b0, 16'h4000, 6'sd0);
      chk_acc("load a", 1'b0, 40'h0040000000);
      seq_u.issue_data(DME_OP_LOAD_ACC, 1'b1, 16'h8000, 6'sd4);
      chk_acc("load shr", 1'b1, 40'hFFF8000000);
      seq_u.issue_data(DME_OP_ADD_DATA, 1'b0, 16'h2000, -6'sd1);
      chk_acc("add shl", 1'b0, 40'h0080000000);
      op(DME_OP_NEG_ACC, 1'b1, 16'h0000, 16'h0000, 1);
      chk_acc("neg b", 1'b1, 40'h0008000000);
      op(DME_OP_MSC, 1'b0, 16'h4000, 16'h4000, 1);
      chk_acc("msc a", 1'b0, 40'h0060000000);
      op(DME_OP_MPY_NEG, 1'b1, 16'h4000, 16'h2000, 1);
      chk_acc("mpy neg", 1'b1, 40'hFFF0000000);
      $display("t_data done");
   endtask
   task automatic end_of_test;
      $display("compares %0d errors %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      err_total = 0;
      compares = 0;
      n_trap = 0;
      n_mul = 0;
      apb = '0;
      i_sys_rst = 1'b1;
      repeat (10) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      t_regs();
      t_frac();
      t_imul();
      t_guard();
      t_sat();
      t_cat();
      t_data();
      end_of_test();
   end
   // whole run needs well under 2000 cycles
   initial
   begin
      #400000;
      err_total++;
      end_of_test();
   end
endmodule
`default_nettype wire
